// >>> hw/clock_synth_config_regs.sv
// APB register bank holding the clock synth configuration words and their decoding
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module clock_synth_config_regs (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins from outside
    input wire logic ref_select_pin,
    input wire logic nvm_lock_status,
    input wire logic first_ref_ok,
    input wire logic second_ref_ok,
    input wire logic crystal_ok,
    input wire logic pfd_tick,
    input wire logic lock_seen,
    // Channel four
    output logic [1:0] chan4_source,
    output logic [6:0] chan4_coarse_phase,
    output logic [6:0] chan4_divide_ratio,
    output logic chan4_divider_enable,
    output logic chan4_high_swing,
    output logic chan4_buf_pecl,
    output logic chan4_buf_lvds,
    output logic chan4_buf_single,
    output logic chan4_buf_off,
    output logic chan4_pos_drive,
    output logic chan4_pos_invert,
    output logic chan4_pos_force_low,
    output logic chan4_neg_drive,
    output logic chan4_neg_invert,
    output logic chan4_neg_force_low,
    // Input buffers
    output logic in_fmt_cmos,
    output logic in_fmt_pecl,
    output logic in_fmt_lvds,
    output logic in_dc_coupled,
    output logic hysteresis_on,
    output logic first_term_on,
    output logic second_term_on,
    output logic first_neg_bias_on,
    output logic second_neg_bias_on,
    output logic input_input_on_a_on,
    // Reference selection
    output logic [1:0] ref_selected,
    output logic ref_auto,
    // PLL
    output logic [7:0] input_divider,
    output logic [3:0] lock_window,
    output logic pll_locked,
    output logic lock_use_analog,
    output logic osc_high_range,
    output logic [1:0] prescaler_setting,
    output logic [7:0] feedback_divider,
    output logic [2:0] bypass_divider,
    output logic [3:0] pump_current_sel,
    output logic pump_pulse_width,
    output logic cal_start,
    output logic sync_delay_mode,
    output logic sync_to_reference,
    output logic side_output_on,
    output logic side_from_div3,
    output logic external_filter_sel,
    output logic [20:0] loop_filter_setting,
    output logic mux_delay_one_long,
    output logic mux_delay_two_long
);
    localparam int N_WORDS = 4;
    logic [27:0] word_reg [N_WORDS];
    logic [1:0] ref_pin_sync_reg;
    logic [2:0] avail_sync1_reg;
    logic [2:0] avail_sync2_reg;
    logic [1:0] nvm_sync_reg;
    logic cal_prev_reg;
    logic cal_start_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // Address decode: word index times four is the byte address
    wire logic addr_aligned = (paddr[1:0] == 2'h0) && (paddr[11:6] == 6'h00);
    wire logic [3:0] addr_idx = paddr[5:2];
    wire logic hit_o4 = addr_aligned && (addr_idx == clk_cfg_pkg::IDX_OUTPUT_FOUR);
    wire logic hit_is = addr_aligned && (addr_idx == clk_cfg_pkg::IDX_INPUT_SELECT);
    wire logic hit_vp = addr_aligned && (addr_idx == clk_cfg_pkg::IDX_VCO_PLL);
    wire logic hit_lf = addr_aligned && (addr_idx == clk_cfg_pkg::IDX_LOOP_FILTER);
    wire logic hit_any = hit_o4 || hit_is || hit_vp || hit_lf;
    wire logic [1:0] word_sel = 2'(addr_idx - clk_cfg_pkg::IDX_OUTPUT_FOUR);
    wire logic access = psel && penable;
    wire logic wr_ok = access && pwrite && hit_any;
    wire logic [27:0] strb_mask = {{4{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    wire logic [27:0] o4 = word_reg[0];
    wire logic [27:0] is_w = word_reg[1];
    wire logic [27:0] vp = word_reg[2];
    wire logic [27:0] lf = word_reg[3];
    wire logic nvm_locked_flag = nvm_sync_reg[1];

    // Zero-wait slave; unmapped or misaligned addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !hit_any;

    genvar gi;
    generate
        for (gi = 0; gi < N_WORDS; gi++) begin : g_word
            logic [27:0] merged;
            assign merged = (word_reg[gi] & ~strb_mask) | (pwdata[27:0] & strb_mask);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    word_reg[gi] <= (gi == 0) ? clk_cfg_pkg::RST_OUTPUT_FOUR :
                                    (gi == 1) ? clk_cfg_pkg::RST_INPUT_SELECT :
                                    (gi == 2) ? clk_cfg_pkg::RST_VCO_PLL :
                                    clk_cfg_pkg::RST_LOOP_FILTER;
                end else if (wr_ok && word_sel == 2'(gi)) begin
                    word_reg[gi] <= merged;
                end
            end
        end
    endgenerate

    // Lock flag substituted on read; stored copy of that bit is never seen
    always_comb begin
        prdata_next = 32'h0000_0000;
        if (hit_any) begin
            prdata_next[27:0] = word_reg[word_sel];
        end
        if (hit_lf) begin
            prdata_next[clk_cfg_pkg::LF_NVM_LOCK] = nvm_locked_flag;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= prdata_next;
        end
    end
    assign prdata = prdata_reg;

    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_pin_sync_reg <= 2'h0;
            avail_sync1_reg <= 3'h0;
            avail_sync2_reg <= 3'h0;
            nvm_sync_reg <= 2'h0;
        end else begin
            ref_pin_sync_reg <= {ref_pin_sync_reg[0], ref_select_pin};
            avail_sync1_reg <= {crystal_ok, second_ref_ok, first_ref_ok};
            avail_sync2_reg <= avail_sync1_reg;
            nvm_sync_reg <= {nvm_sync_reg[0], nvm_lock_status};
        end
    end

    // Channel four
    assign chan4_source = {o4[clk_cfg_pkg::O4_SRC_LO], o4[clk_cfg_pkg::O4_SRC_LO + 1]};
    assign chan4_coarse_phase = o4[clk_cfg_pkg::O4_PHASE_LO +: 7];
    assign chan4_divide_ratio = o4[clk_cfg_pkg::O4_DIV_LO +: 7];
    assign chan4_divider_enable = o4[clk_cfg_pkg::O4_DIV_EN];
    assign sync_delay_mode = o4[clk_cfg_pkg::O4_SYNC_DELAY];
    wire logic [5:0] buf_code = o4[clk_cfg_pkg::O4_POS_MODE +: 6];
    wire logic [1:0] buf_hi = o4[clk_cfg_pkg::O4_BUF_TYPE +: 2];
    wire logic [1:0] pos_mode = o4[clk_cfg_pkg::O4_POS_MODE +: 2];
    wire logic [1:0] neg_mode = o4[clk_cfg_pkg::O4_NEG_MODE +: 2];
    assign chan4_buf_pecl = (buf_code == clk_cfg_pkg::BUF_PECL);
    assign chan4_buf_lvds = (buf_code == clk_cfg_pkg::BUF_LVDS);
    assign chan4_buf_off = (buf_code == clk_cfg_pkg::BUF_OFF);
    assign chan4_buf_single = (buf_hi == 2'h0);
    // High swing only meaningful with PECL; gated by chan4_buf_pecl so it reads clear otherwise
    assign chan4_high_swing = o4[clk_cfg_pkg::O4_HI_SWING] && chan4_buf_pecl;
    // Pin mode pairs are written X then Y, X landing on the lower bit
    wire logic [1:0] pos_xy = {pos_mode[0], pos_mode[1]};
    wire logic [1:0] neg_xy = {neg_mode[0], neg_mode[1]};
    assign chan4_pos_drive = chan4_buf_single && (pos_xy != clk_cfg_pkg::PIN_HIZ);
    assign chan4_pos_invert = chan4_buf_single && (pos_xy == clk_cfg_pkg::PIN_INV);
    assign chan4_pos_force_low = chan4_buf_single && (pos_xy == clk_cfg_pkg::PIN_LOW);
    assign chan4_neg_drive = chan4_buf_single && (neg_xy != clk_cfg_pkg::PIN_HIZ);
    assign chan4_neg_invert = chan4_buf_single && (neg_xy == clk_cfg_pkg::PIN_INV);
    assign chan4_neg_force_low = chan4_buf_single && (neg_xy == clk_cfg_pkg::PIN_LOW);

    // Input buffers
    wire logic [1:0] fmt = is_w[clk_cfg_pkg::IS_FORMAT +: 2];
    assign in_fmt_cmos = (fmt == clk_cfg_pkg::FMT_CMOS);
    assign in_fmt_pecl = (fmt == clk_cfg_pkg::FMT_PECL);
    assign in_fmt_lvds = (fmt == clk_cfg_pkg::FMT_LVDS);
    assign in_dc_coupled = is_w[clk_cfg_pkg::IS_COUPLING];
    assign hysteresis_on = is_w[clk_cfg_pkg::IS_HYST];
    assign first_term_on = !is_w[clk_cfg_pkg::IS_FIRST_TERM];
    assign second_term_on = !vp[clk_cfg_pkg::VP_SECOND_TERM];
    assign first_neg_bias_on = !is_w[clk_cfg_pkg::IS_FIRST_BIAS];
    assign second_neg_bias_on = !is_w[clk_cfg_pkg::IS_SECOND_BIAS];
    assign input_input_on_a_on = is_w[clk_cfg_pkg::IS_INPUT_ON_A] && in_fmt_lvds
                               && in_dc_coupled;

    // Reference selection; bits 2,3,4 read as first, second, crystal
    wire logic [2:0] src_field = is_w[clk_cfg_pkg::IS_SRC +: 3];
    wire logic internal_sel = is_w[clk_cfg_pkg::IS_INTERNAL];
    wire logic [2:0] avail = avail_sync2_reg;
    logic [1:0] auto_pick;
    always_comb begin
        if (avail[0]) begin
            auto_pick = 2'h0;
        end else if (avail[1] || src_field != clk_cfg_pkg::SEL_AUTO3) begin
            auto_pick = 2'h1;
        end else begin
            auto_pick = 2'h2;
        end
    end
    wire logic is_auto = (src_field == clk_cfg_pkg::SEL_AUTO2)
                         || (src_field == clk_cfg_pkg::SEL_AUTO3);
    assign ref_auto = internal_sel && is_auto;
    assign ref_selected = !internal_sel ? {1'b0, ref_pin_sync_reg[1]} :
                          is_auto ? auto_pick :
                          (src_field == clk_cfg_pkg::SEL_CRYSTAL) ? 2'h2 :
                          (src_field == clk_cfg_pkg::SEL_SECOND) ? 2'h1 : 2'h0;

    // PLL
    assign input_divider = is_w[clk_cfg_pkg::IS_IN_DIV +: 8];
    assign lock_window = is_w[clk_cfg_pkg::IS_LOCK_WIN +: 4];
    assign lock_use_analog = is_w[clk_cfg_pkg::IS_LOCK_TYPE];
    assign osc_high_range = vp[clk_cfg_pkg::VP_OSC_RANGE];
    assign prescaler_setting = vp[clk_cfg_pkg::VP_PRESC +: 2];
    assign feedback_divider = vp[clk_cfg_pkg::VP_FB_DIV +: 8];
    assign bypass_divider = vp[clk_cfg_pkg::VP_BYP_DIV +: 3];
    assign pump_current_sel = vp[clk_cfg_pkg::VP_PUMP_I +: 4];
    assign pump_pulse_width = vp[clk_cfg_pkg::VP_PUMP_WIDTH];
    assign sync_to_reference = !vp[clk_cfg_pkg::VP_SYNC_ALIGN];
    assign side_output_on = vp[clk_cfg_pkg::VP_SIDE_ON];
    assign side_from_div3 = vp[clk_cfg_pkg::VP_SIDE_SRC];
    assign external_filter_sel = vp[clk_cfg_pkg::VP_EXT_FILTER];
    assign loop_filter_setting = lf[clk_cfg_pkg::LF_SETTING +: 21];
    assign mux_delay_one_long = lf[clk_cfg_pkg::LF_DELAY_ONE];
    assign mux_delay_two_long = lf[clk_cfg_pkg::LF_DELAY_TWO];

    lock_qualifier u_lock (
        .pclk(pclk),
        .presetn(presetn),
        .pfd_tick(pfd_tick),
        .lock_seen(lock_seen),
        .need_run(is_w[clk_cfg_pkg::IS_LOCK_CNT]),
        .locked(pll_locked)
    );

    // Calibration pulse on a stored 0->1 of the trigger bit in manual mode
    wire logic cal_now = vp[clk_cfg_pkg::VP_CAL_TRIG];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_prev_reg <= 1'b0;
            cal_start_reg <= 1'b0;
        end else begin
            cal_prev_reg <= cal_now;
            cal_start_reg <= cal_now && !cal_prev_reg && vp[clk_cfg_pkg::VP_CAL_MANUAL];
        end
    end
    assign cal_start = cal_start_reg;
endmodule // clock_synth_config_regs

// >>> hw/clk_cfg_pkg.sv
// Package with register map, field positions and encodings of the clock synth config bank
package clk_cfg_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_OUTPUT_FOUR = 4'h4;
    localparam logic [3:0] IDX_INPUT_SELECT = 4'h5;
    localparam logic [3:0] IDX_VCO_PLL = 4'h6;
    localparam logic [3:0] IDX_LOOP_FILTER = 4'h7;
    // Reset values
    localparam logic [27:0] RST_OUTPUT_FOUR = 28'h0000001;
    localparam logic [27:0] RST_INPUT_SELECT = 28'h0000080;
    localparam logic [27:0] RST_VCO_PLL = 28'h0000000;
    localparam logic [27:0] RST_LOOP_FILTER = 28'h1400000;
    // Output four word
    localparam int O4_SYNC_DELAY = 1;
    localparam int O4_SRC_LO = 4;
    localparam int O4_PHASE_LO = 6;
    localparam int O4_DIV_LO = 13;
    localparam int O4_DIV_EN = 20;
    localparam int O4_HI_SWING = 21;
    localparam int O4_POS_MODE = 22;
    localparam int O4_NEG_MODE = 24;
    localparam int O4_BUF_TYPE = 26;
    // Input select word
    localparam int IS_FORMAT = 0;
    localparam int IS_SRC = 2;
    localparam int IS_INTERNAL = 5;
    localparam int IS_COUPLING = 6;
    localparam int IS_HYST = 7;
    localparam int IS_FIRST_TERM = 8;
    localparam int IS_FIRST_BIAS = 9;
    localparam int IS_SECOND_BIAS = 10;
    localparam int IS_INPUT_ON_A = 11;
    localparam int IS_IN_DIV = 14;
    localparam int IS_LOCK_WIN = 22;
    localparam int IS_LOCK_CNT = 26;
    localparam int IS_LOCK_TYPE = 27;
    // VCO and PLL word
    localparam int VP_OSC_RANGE = 0;
    localparam int VP_PRESC = 1;
    localparam int VP_FB_DIV = 3;
    localparam int VP_SECOND_TERM = 12;
    localparam int VP_BYP_DIV = 13;
    localparam int VP_PUMP_I = 16;
    localparam int VP_SYNC_ALIGN = 20;
    localparam int VP_PUMP_WIDTH = 21;
    localparam int VP_CAL_TRIG = 22;
    localparam int VP_SIDE_ON = 24;
    localparam int VP_SIDE_SRC = 25;
    localparam int VP_EXT_FILTER = 26;
    localparam int VP_CAL_MANUAL = 27;
    // Loop filter word
    localparam int LF_SETTING = 0;
    localparam int LF_DELAY_TWO = 23;
    localparam int LF_DELAY_ONE = 25;
    localparam int LF_NVM_LOCK = 26;
    // Encodings
    localparam logic [1:0] SRC_FIRST = 2'h0;
    localparam logic [1:0] SRC_SECOND = 2'h1;
    localparam logic [1:0] SRC_SMART = 2'h2;
    localparam logic [1:0] SRC_CORE = 2'h3;
    localparam logic [1:0] PIN_TRUE = 2'h0;
    localparam logic [1:0] PIN_HIZ = 2'h1;
    localparam logic [1:0] PIN_INV = 2'h2;
    localparam logic [1:0] PIN_LOW = 2'h3;
    localparam logic [5:0] BUF_PECL = 6'h20;
    localparam logic [5:0] BUF_LVDS = 6'h3A;
    localparam logic [5:0] BUF_OFF = 6'h1A;
    localparam logic [1:0] FMT_CMOS = 2'h0;
    localparam logic [1:0] FMT_PECL = 2'h2;
    localparam logic [1:0] FMT_LVDS = 2'h3;
    localparam logic [2:0] SEL_FIRST = 3'h1;
    localparam logic [2:0] SEL_SECOND = 3'h2;
    localparam logic [2:0] SEL_CRYSTAL = 3'h4;
    localparam logic [2:0] SEL_AUTO2 = 3'h3;
    localparam logic [2:0] SEL_AUTO3 = 3'h7;
    localparam logic [6:0] LOCK_RUN = 7'h40;
endpackage

// >>> hw/lock_qualifier.sv
// Lock qualifier: one event or a run of consecutive phase-detector cycles
`timescale 1ns/10ps
module lock_qualifier (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Lock detector
    input wire logic pfd_tick,
    input wire logic lock_seen,
    input wire logic need_run,
    // Result
    output logic locked
);
    logic [6:0] run_reg;
    logic [6:0] run_next;
    logic locked_reg;
    logic locked_next;
    wire logic run_full = (run_reg == clk_cfg_pkg::LOCK_RUN);

    assign run_next = !lock_seen ? 7'h00 : (pfd_tick && !run_full) ? run_reg + 7'h01 : run_reg;
    // Single event suffices unless a full run is needed
    assign locked_next = lock_seen && (need_run ? run_full : 1'b1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= 7'h00;
            locked_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
            locked_reg <= locked_next;
        end
    end

    assign locked = locked_reg;
endmodule // lock_qualifier

// >>> verif/clock_synth_config_regs_asserts.sv
// Assertion checker for the clock synth configuration register bank
`timescale 1ns/10ps
module clock_synth_config_regs_asserts (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // Lock and calibration
    input wire logic lock_seen,
    input wire logic pll_locked,
    input wire logic cal_start,
    // Decoded outputs
    input wire logic [1:0] chan4_source,
    input wire logic chan4_buf_pecl,
    input wire logic chan4_buf_lvds,
    input wire logic chan4_high_swing,
    input wire logic in_fmt_lvds,
    input wire logic in_dc_coupled,
    input wire logic input_input_on_a_on
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel & penable;
    wire wr_o4 = acc & pwrite & (paddr == 12'h010);
    wire wr_vp = acc & pwrite & (paddr == 12'h018);
    wire bad_addr = (paddr[1:0] != 2'h0) | (paddr < 12'h010) | (paddr > 12'h01C);
    wire [1:0] src_code = {pwdata[4], pwdata[5]};
    logic trig_reg;
    // Last written trigger bit, so only a true low-to-high write counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            trig_reg <= 1'h0;
        else if (wr_vp)
            trig_reg <= pwdata[22];
    end
    sequence s_cal_edge;
        wr_vp && pwdata[27] && pwdata[22] && !trig_reg;
    endsequence
    sequence s_one_pulse;
        ##[1:3] cal_start ##1 !cal_start;
    endsequence
    property p_err; acc |-> pslverr == bad_addr; endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_src; wr_o4 |=> chan4_source == $past(src_code); endproperty
    a_src: assert property (p_src) else $error("channel source wrong");
    property p_lvds; wr_o4 && pwdata[27:22] == 6'h3A |=> chan4_buf_lvds && !chan4_buf_pecl; endproperty
    a_lvds: assert property (p_lvds) else $error("buffer type wrong");
    property p_swing; chan4_high_swing |-> chan4_buf_pecl; endproperty
    a_swing: assert property (p_swing) else $error("high swing outside pecl");
    property p_cal; s_cal_edge |-> s_one_pulse; endproperty
    a_cal: assert property (p_cal) else $error("calibration pulse missing");
    property p_cal_block; wr_vp && !pwdata[27] |=> !cal_start [*3]; endproperty
    a_cal_block: assert property (p_cal_block) else $error("calibration in startup mode");
    property p_unlock; !lock_seen |=> !pll_locked; endproperty
    a_unlock: assert property (p_unlock) else $error("lock held without detector");
    property p_fs; input_input_on_a_on |-> in_fmt_lvds && in_dc_coupled; endproperty
    a_fs: assert property (p_fs) else $error("fail-safe outside dc lvds");
endmodule // clock_synth_config_regs_asserts

bind clock_synth_config_regs clock_synth_config_regs_asserts chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .lock_seen(lock_seen),
    .pll_locked(pll_locked), .cal_start(cal_start), .chan4_source(chan4_source),
    .chan4_buf_pecl(chan4_buf_pecl), .chan4_buf_lvds(chan4_buf_lvds),
    .chan4_high_swing(chan4_high_swing), .in_fmt_lvds(in_fmt_lvds),
    .in_dc_coupled(in_dc_coupled), .input_input_on_a_on(input_input_on_a_on));

// >>> verif/tb_top.sv
// Self-checking testbench for the clock synth configuration register bank
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
    localparam logic [11:0] A_O4 = {6'h00, clk_cfg_pkg::IDX_OUTPUT_FOUR, 2'h0};
    localparam logic [11:0] A_IS = {6'h00, clk_cfg_pkg::IDX_INPUT_SELECT, 2'h0};
    localparam logic [11:0] A_VP = {6'h00, clk_cfg_pkg::IDX_VCO_PLL, 2'h0};
    localparam logic [11:0] A_LF = {6'h00, clk_cfg_pkg::IDX_LOOP_FILTER, 2'h0};
    int n_mismatch = 0;
    int samples_checked = 0;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic ref_select_pin = 1'h0, nvm_lock_status = 1'h0, first_ref_ok = 1'h1;
    logic second_ref_ok = 1'h1, crystal_ok = 1'h1, pfd_tick = 1'h0, lock_seen = 1'h0;
    logic [31:0] prdata;
    logic [1:0] chan4_source, ref_selected;
    logic [20:0] loop_filter_setting;
    logic pready, pslverr, chan4_high_swing, chan4_buf_pecl, chan4_buf_lvds, chan4_buf_single;
    logic chan4_buf_off, chan4_pos_drive, chan4_pos_invert, chan4_pos_force_low, chan4_neg_drive;
    logic chan4_neg_invert, chan4_neg_force_low, in_fmt_cmos, in_fmt_pecl, in_fmt_lvds;
    logic in_dc_coupled, hysteresis_on, first_term_on, second_term_on, first_neg_bias_on;
    logic second_neg_bias_on, input_input_on_a_on, ref_auto, pll_locked, lock_use_analog;
    logic osc_high_range, cal_start, sync_to_reference, side_output_on, side_from_div3;
    logic external_filter_sel, mux_delay_one_long, mux_delay_two_long;
    wire logic [5:0] vco_bits = {osc_high_range, sync_to_reference, side_output_on,
        side_from_div3, external_filter_sel, second_term_on};
    clock_synth_config_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .ref_select_pin, .nvm_lock_status, .first_ref_ok,
        .second_ref_ok, .crystal_ok, .pfd_tick, .lock_seen, .chan4_source,
        .chan4_coarse_phase(), .chan4_divide_ratio(), .chan4_divider_enable(),
        .chan4_high_swing, .chan4_buf_pecl, .chan4_buf_lvds, .chan4_buf_single, .chan4_buf_off,
        .chan4_pos_drive, .chan4_pos_invert, .chan4_pos_force_low, .chan4_neg_drive,
        .chan4_neg_invert, .chan4_neg_force_low, .in_fmt_cmos, .in_fmt_pecl, .in_fmt_lvds,
        .in_dc_coupled, .hysteresis_on, .first_term_on, .second_term_on, .first_neg_bias_on,
        .second_neg_bias_on, .input_input_on_a_on, .ref_selected, .ref_auto, .input_divider(),
        .lock_window(), .pll_locked, .lock_use_analog, .osc_high_range, .prescaler_setting(),
        .feedback_divider(), .bypass_divider(), .pump_current_sel(), .pump_pulse_width(),
        .cal_start, .sync_delay_mode(), .sync_to_reference, .side_output_on, .side_from_div3,
        .external_filter_sel, .loop_filter_setting, .mux_delay_one_long, .mux_delay_two_long);
    initial begin
        forever #20 pclk = ~pclk;
    end
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Idle edge between transfers
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'h1, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(a, 1'h0, 32'h0, r, e);
        `CHK(r, x)
        `CHK(e, xe)
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic cal_try(input logic [31:0] d, input int x);
        int n = 0;
        wr(A_VP, d);
        repeat (6) begin
            @(negedge pclk);
            if (cal_start === 1'h1) n++;
        end
        @(posedge pclk);
        `CHK(n, x)
    endtask
    task automatic lock_after(input int n, input logic x);
        settle(n);
        @(negedge pclk);
        `CHK(pll_locked, x)
        @(posedge pclk);
    endtask
    task automatic test_reset();
        logic [31:0] r;
        logic e;
        rd(A_O4, {4'h0, clk_cfg_pkg::RST_OUTPUT_FOUR}, 1'h0);
        rd(A_IS, {4'h0, clk_cfg_pkg::RST_INPUT_SELECT}, 1'h0);
        rd(A_VP, {4'h0, clk_cfg_pkg::RST_VCO_PLL}, 1'h0);
        rd(A_LF, {4'h0, clk_cfg_pkg::RST_LOOP_FILTER}, 1'h0);
        apb(12'h020, 1'h1, 32'hFFFFFFFF, r, e);
        `CHK(e, 1'h1)
        rd(12'h012, 32'h0, 1'h1);
        `CHK(hysteresis_on, 1'h1)
        $display("test reset done");
    endtask
    task automatic test_out4();
        logic [31:0] v;
        logic [1:0] c;
        logic [5:0] bt [3] = '{clk_cfg_pkg::BUF_PECL, clk_cfg_pkg::BUF_LVDS, clk_cfg_pkg::BUF_OFF};
        logic [3:0] ex [3] = '{4'h8, 4'h4, 4'h1};
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            v = {4'h0, 2'h0, c[0], c[1], c[0], c[1], 16'h0000, c[0], c[1], 4'h1};
            wr(A_O4, v);
            rd(A_O4, v, 1'h0);
            `CHK(chan4_source, c)
            `CHK(chan4_buf_single, 1'h1)
            `CHK({chan4_pos_invert, chan4_pos_force_low}, {c == 2'h2, c == 2'h3})
            `CHK({chan4_neg_invert, chan4_neg_force_low}, {c == 2'h2, c == 2'h3})
            `CHK({chan4_pos_drive, chan4_neg_drive}, {2{c != 2'h1}})
        end
        for (int j = 0; j < 3; j++) begin
            v = {4'h0, bt[j], j == 0, 21'h000001};
            wr(A_O4, v);
            `CHK({chan4_buf_pecl, chan4_buf_lvds, chan4_buf_single, chan4_buf_off}, ex[j])
            `CHK(chan4_high_swing, v[21])
        end
        $display("test output four done");
    endtask
    task automatic test_input();
        for (int f = 0; f < 3; f++) begin
            for (int d = 0; d < 2; d++) begin
                wr(A_IS, 32'h880 | 32'(f + (f > 0)) | 32'(d << 6));
                `CHK({in_fmt_cmos, in_fmt_pecl, in_fmt_lvds}, 3'h4 >> f)
                `CHK(in_dc_coupled, 1'(d))
                `CHK(input_input_on_a_on, 1'(f == 2 && d == 1))
            end
        end
        wr(A_IS, 32'h480);
        `CHK({first_term_on, first_neg_bias_on, second_neg_bias_on}, 3'h6)
        wr(A_IS, 32'h380);
        `CHK({first_term_on, first_neg_bias_on, second_neg_bias_on}, 3'h1)
        $display("test input buffers done");
    endtask
    task automatic test_ref();
        logic [2:0] sc [3] = '{clk_cfg_pkg::SEL_FIRST, clk_cfg_pkg::SEL_SECOND,
                               clk_cfg_pkg::SEL_CRYSTAL};
        for (int k = 0; k < 3; k++) begin
            wr(A_IS, 32'hA0 | 32'(sc[k]) << 2);
            `CHK({ref_selected, ref_auto}, {2'(k), 1'h0})
        end
        first_ref_ok <= 1'h0;
        wr(A_IS, 32'hA0 | 32'(clk_cfg_pkg::SEL_AUTO2) << 2);
        settle(3);
        `CHK({ref_selected, ref_auto}, 3'h3)
        second_ref_ok <= 1'h0;
        wr(A_IS, 32'hA0 | 32'(clk_cfg_pkg::SEL_AUTO3) << 2);
        settle(3);
        `CHK({ref_selected, ref_auto}, 3'h5)
        ref_select_pin <= 1'h1;
        wr(A_IS, 32'h80 | 32'(clk_cfg_pkg::SEL_AUTO3) << 2);
        settle(3);
        `CHK({ref_selected, ref_auto}, 3'h2)
        ref_select_pin <= 1'h0;
        first_ref_ok <= 1'h1;
        second_ref_ok <= 1'h1;
        settle(4);
        `CHK({ref_selected, ref_auto}, 3'h0)
        $display("test reference select done");
    endtask
    task automatic test_vco();
        wr(A_VP, 32'h7001001);
        `CHK(vco_bits, 6'h3E)
        wr(A_VP, 32'h0100000);
        `CHK(vco_bits, 6'h01)
        wr(A_VP, 32'h8000000);
        cal_try(32'h8400000, 1);
        cal_try(32'h8400000, 0);
        wr(A_VP, 32'h0000000);
        cal_try(32'h0400000, 0);
        $display("test vco done");
    endtask
    task automatic test_lf();
        wr(A_LF, 32'h74AAAAA);
        `CHK({mux_delay_one_long, mux_delay_two_long}, 2'h2)
        `CHK(loop_filter_setting, 21'h0AAAAA)
        rd(A_LF, 32'h34AAAAA, 1'h0);
        nvm_lock_status <= 1'h1;
        wr(A_LF, 32'h1C00000);
        `CHK({mux_delay_one_long, mux_delay_two_long}, 2'h1)
        rd(A_LF, 32'h5C00000, 1'h0);
        $display("test loop filter done");
    endtask
    task automatic test_lock();
        wr(A_IS, 32'h8000080);
        `CHK(lock_use_analog, 1'h1)
        lock_seen <= 1'h1;
        lock_after(2, 1'h1);
        lock_seen <= 1'h0;
        wr(A_IS, 32'h4000080);
        `CHK({lock_use_analog, pll_locked}, 2'h0)
        lock_seen <= 1'h1;
        pfd_tick <= 1'h1;
        // One tick short of the run must not lock
        lock_after(63, 1'h0);
        pfd_tick <= 1'h0;
        lock_after(2, 1'h1);
        lock_seen <= 1'h0;
        $display("test lock detect done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        settle(6);
        presetn <= 1'h1;
        @(posedge pclk);
        test_reset();
        test_out4();
        test_input();
        test_ref();
        test_vco();
        test_lf();
        test_lock();
        summarize();
    end
    initial begin
        settle(5000);
        n_mismatch++;
        summarize();
    end
endmodule // tb_top
